// file: rtl/fse_pkg.sv
// fail-safe escalation: shared constants, field positions and types
// assumes a single 10 MHz core clock and an active-high power-on reset
package fse_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ       = 10;
    localparam int CLK_KHZ       = 10000;
    // reset pulse width is not fixed by the device, plain default
    localparam int RST_PULSE_US  = 1000;
    localparam int RST_PULSE_CYC = RST_PULSE_US * CLK_MHZ;
    // reset held low longer than eight seconds forces deep fail-safe
    localparam int LONG_RST_MS   = 8000;
    localparam int LONG_RST_CYC  = LONG_RST_MS * CLK_KHZ;
    localparam int PULSE_W       = 14;
    localparam int LONG_W        = 27;
    // cycles a driven-low pin needs before its readback is trusted
    localparam logic [3:0] SENSE_SETTLE = 4'h6;

    // ------------------------------------------------------------------
    // reset event counter levels
    // ------------------------------------------------------------------
    localparam logic [2:0] CNT_ZERO   = 3'h0;
    localparam logic [2:0] CNT_ONE    = 3'h1;
    localparam logic [2:0] CNT_PRESET = 3'h1;
    localparam logic [2:0] INTER_LO   = 3'h3;
    localparam logic [2:0] FINAL_LO   = 3'h6;
    localparam logic [2:0] INTER_HI   = 3'h1;
    localparam logic [2:0] FINAL_HI   = 3'h2;

    // ------------------------------------------------------------------
    // watchdog counters
    // ------------------------------------------------------------------
    localparam logic [2:0] REFRESH_COUNT_LIMIT = 3'h6;
    localparam logic [2:0] REFRESH_STEP        = 3'h1;
    localparam logic [3:0] WDE_LIMIT           = 4'h6;
    localparam logic [3:0] WDE_FAIL_STEP       = 4'h2;
    localparam logic [3:0] WDE_OK_STEP         = 4'h1;
    localparam logic [3:0] WDE_ZERO            = 4'h0;

    // ------------------------------------------------------------------
    // protected safety configuration word
    // ------------------------------------------------------------------
    localparam int CFG_W  = 8;
    localparam int CODE_W = 13;
    localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
    localparam int CFG_THR_SEL = 0;  // escalation_threshold_select
    localparam int CFG_IO_FS   = 1;  // i/o pair error drives fail-safe
    localparam int CFG_UV_FS   = 2;  // undervoltage drives fail-safe
    localparam int CFG_OV_FS   = 3;  // overvoltage drives fail-safe
    localparam int CFG_FB_FS   = 4;  // core feedback mismatch drives fail-safe

    // ------------------------------------------------------------------
    // synchronised pin inputs
    // ------------------------------------------------------------------
    localparam int NPIN          = 4;
    localparam int PIN_WAKE      = 0;
    localparam int PIN_EXT_RST_N = 1;
    localparam int PIN_RST_SENSE = 2;
    localparam int PIN_FS_SENSE  = 3;
    localparam logic [NPIN-1:0] PIN_RESET = 4'h2;

    typedef enum logic [0:0] {
        ST_RUN  = 1'b0,
        ST_DEEP = 1'b1
    } fse_state_e;

endpackage

// file: rtl/fse_cfg_if.sv
// fail-safe escalation: carrier between escalation core and protected store
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface fse_cfg_if;
    logic                           wr;
    logic [fse_pkg::CFG_W-1:0]      wdata;
    logic                           protect;
    logic [fse_pkg::CODE_W-1:0]     flip;
    logic [fse_pkg::CFG_W-1:0]      rdata;
    logic                           sec;
    logic                           ded;

    modport owner (output wr, output wdata, output protect, output flip,
                   input rdata, input sec, input ded);
    modport store (input wr, input wdata, input protect, input flip,
                   output rdata, output sec, output ded);
endinterface

// file: rtl/fse_secded_reg.sv
// fail-safe escalation: hamming-protected safety configuration word
// assumes writes are only offered while the owner keeps protect low
`timescale 1ns/1ps
module fse_secded_reg (
    input  wire logic   mclk_i,
    input  wire logic   rst_i,
    fse_cfg_if.store    cfg
);

    // ------------------------------------------------------------------
    // code construction: positions 1..12 hamming, bit 0 overall parity
    // ------------------------------------------------------------------
    function automatic logic [fse_pkg::CODE_W-1:0] enc(input logic [fse_pkg::CFG_W-1:0] d);
        logic [fse_pkg::CODE_W-1:0] c;
        c     = '0;
        c[3]  = d[0];
        c[5]  = d[1];
        c[6]  = d[2];
        c[7]  = d[3];
        c[9]  = d[4];
        c[10] = d[5];
        c[11] = d[6];
        c[12] = d[7];
        c[1]  = c[3] ^ c[5] ^ c[7] ^ c[9] ^ c[11];
        c[2]  = c[3] ^ c[6] ^ c[7] ^ c[10] ^ c[11];
        c[4]  = c[5] ^ c[6] ^ c[7] ^ c[12];
        c[8]  = c[9] ^ c[10] ^ c[11] ^ c[12];
        c[0]  = ^c[12:1];
        return c;
    endfunction

    logic [fse_pkg::CODE_W-1:0] code;
    logic [3:0]                 syn;
    logic                       par;
    logic                       single_err;
    logic                       double_err;
    logic [fse_pkg::CODE_W-1:0] fixed;

    // ------------------------------------------------------------------
    // check and correct
    // ------------------------------------------------------------------
    assign syn[0]     = code[1] ^ code[3] ^ code[5] ^ code[7] ^ code[9] ^ code[11];
    assign syn[1]     = code[2] ^ code[3] ^ code[6] ^ code[7] ^ code[10] ^ code[11];
    assign syn[2]     = code[4] ^ code[5] ^ code[6] ^ code[7] ^ code[12];
    assign syn[3]     = code[8] ^ code[9] ^ code[10] ^ code[11] ^ code[12];
    assign par        = ^code;
    // a syndrome past the last position with odd parity is not correctable
    assign single_err = cfg.protect & par & (syn <= 4'hC);
    assign double_err = cfg.protect & ((~par & (syn != 4'h0)) | (par & (syn > 4'hC)));
    assign fixed      = single_err ? (code ^ (13'h0001 << syn)) : code;
    // readback is the corrected word, so a single upset stays invisible
    assign cfg.rdata  = {fixed[12], fixed[11], fixed[10], fixed[9], fixed[7], fixed[6], fixed[5], fixed[3]};
    assign cfg.sec    = single_err;
    assign cfg.ded    = double_err;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            code <= enc(fse_pkg::CFG_RESET);
        end else if (cfg.wr && !cfg.protect) begin
            code <= enc(cfg.wdata);
        end else begin
            code <= fixed ^ cfg.flip;  // scrubbed word, then any injected upset
        end
    end

endmodule

// file: rtl/fse_escalation.sv
// fail-safe escalation: reset event counter, reset/fail-safe outputs,
// deep fail-safe, release key check and protected configuration.
// assumes watchdog, supervisor and spi decode sit outside on the same clock;
// pin inputs are asynchronous and pass a three-stage filter here.
//
// Operation
// - every generated reset adds one to counter
// - one bit picks intermediate threshold one or three
// - bit low: fail-safe at three, deep at six
// - bit high: fail-safe at one, deep at two
// - deep: regulators off, outputs held, wake exits
// - reset low beyond eight seconds forces deep
// - listed fault and watchdog events count resets
// - self-test, double error, reset short always fail-safe
// - start-up or resume: counter one, fail-safe asserted
// - seven good refreshes bring counter one to zero
// - release needs no fault, zero count, key
// - key is challenge word reversed and inverted
// - config free in init, then hamming protected
// - single upset corrected silently, flag raised
// - double upset: flag, no correction, both asserted
// - refresh after limit of six decrements counter
// - wrong refresh clears refresh counter
// - failure adds two, good refresh subtracts one
`timescale 1ns/1ps
module fse_escalation #(
    parameter int RST_PULSE_CYC = fse_pkg::RST_PULSE_CYC,
    parameter int LONG_RST_CYC  = fse_pkg::LONG_RST_CYC
) (
    input  wire logic                       mclk_i,
    input  wire logic                       rst_i,
    input  wire logic                       wake_pin_i,
    input  wire logic                       ext_reset_n_i,
    input  wire logic                       rst_sense_i,
    input  wire logic                       fs_sense_i,
    input  wire logic                       safety_init_phase_i,
    input  wire logic                       low_power_off_resume_i,
    input  wire logic                       cfg_wr_i,
    input  wire logic [fse_pkg::CFG_W-1:0]  cfg_wdata_i,
    input  wire logic [fse_pkg::CODE_W-1:0] cfg_upset_i,
    input  wire logic                       key_wr_i,
    input  wire logic [7:0]                 key_wdata_i,
    input  wire logic [7:0]                 wd_challenge_word_i,
    input  wire logic                       wd_ok_i,
    input  wire logic                       wd_bad_i,
    input  wire logic                       wd_timeout_i,
    input  wire logic                       io_pair_err_i,
    input  wire logic                       undervolt_i,
    input  wire logic                       overvolt_i,
    input  wire logic                       core_fb_err_i,
    input  wire logic                       analog_self_test_fail_i,
    input  wire logic                       spi_reset_req_i,
    input  wire logic                       sec_flag_clr_i,
    output logic                            mcu_reset_out_n_o,
    output logic                            failsafe_out_n_o,
    output logic                            regulators_off_o,
    output logic                            deep_failsafe_o,
    output logic [2:0]                      reset_count_o,
    output logic [fse_pkg::CFG_W-1:0]       cfg_rdata_o,
    output logic                            sec_flag_o,
    output logic                            double_error_detect_o,
    output logic                            key_good_o
);

    fse_cfg_if cfg_bus ();

    fse_secded_reg u_store (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .cfg    (cfg_bus.store)
    );

    // ------------------------------------------------------------------
    // pin synchronisers: three stages, a change counts once 2nd and 3rd agree
    // ------------------------------------------------------------------
    logic [fse_pkg::NPIN-1:0] pin_s1;
    logic [fse_pkg::NPIN-1:0] pin_s2;
    logic [fse_pkg::NPIN-1:0] pin_s3;
    logic [fse_pkg::NPIN-1:0] pin_f;
    wire  [fse_pkg::NPIN-1:0] pin_raw = {fs_sense_i, rst_sense_i, ext_reset_n_i, wake_pin_i};
    wire  [fse_pkg::NPIN-1:0] pin_upd = ~(pin_s2 ^ pin_s3) & (pin_s3 ^ pin_f);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1 <= fse_pkg::PIN_RESET;
            pin_s2 <= fse_pkg::PIN_RESET;
            pin_s3 <= fse_pkg::PIN_RESET;
            pin_f  <= fse_pkg::PIN_RESET;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f  <= pin_f ^ pin_upd;
        end
    end

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    fse_pkg::fse_state_e            state;
    logic [2:0]                     cnt;
    logic [2:0]                     refresh_cnt;
    logic [3:0]                     wde_cnt;
    logic                           fs_hold;
    logic                           key_good;
    logic                           sec_flag;
    logic [fse_pkg::PULSE_W-1:0]    pulse_cnt;
    logic [fse_pkg::LONG_W-1:0]     long_cnt;
    logic [3:0]                     fs_low_cnt;
    logic [5:0]                     lvl_q;

    // ------------------------------------------------------------------
    // configuration and fault decode
    // ------------------------------------------------------------------
    wire       deep      = (state == fse_pkg::ST_DEEP);
    wire [7:0] cfg       = cfg_bus.rdata;
    wire       ded       = cfg_bus.ded;
    // threshold bit only writable in init
    assign cfg_bus.wr      = cfg_wr_i;
    assign cfg_bus.wdata   = cfg_wdata_i;
    assign cfg_bus.protect = ~safety_init_phase_i;
    assign cfg_bus.flip    = cfg_upset_i;
    wire       thr_sel   = cfg[fse_pkg::CFG_THR_SEL];
    wire [2:0] inter_lvl = thr_sel ? fse_pkg::INTER_HI : fse_pkg::INTER_LO;
    wire [2:0] final_lvl = thr_sel ? fse_pkg::FINAL_HI : fse_pkg::FINAL_LO;
    // settled low drive only, so our own edge is no short
    wire       rst_short = (long_cnt >= fse_pkg::LONG_W'(fse_pkg::SENSE_SETTLE)) & pin_f[fse_pkg::PIN_RST_SENSE];
    wire       fs_short  = (fs_low_cnt == fse_pkg::SENSE_SETTLE) & pin_f[fse_pkg::PIN_FS_SENSE];
    wire       fault_fix = analog_self_test_fail_i | ded | rst_short;
    wire       fault_cfg = (io_pair_err_i & cfg[fse_pkg::CFG_IO_FS]) | (undervolt_i & cfg[fse_pkg::CFG_UV_FS])
                         | (overvolt_i & cfg[fse_pkg::CFG_OV_FS]) | (core_fb_err_i & cfg[fse_pkg::CFG_FB_FS]);
    wire       fault_now = fault_fix | fault_cfg;
    wire [5:0] lvl       = {fs_short, ded, core_fb_err_i, overvolt_i, undervolt_i, io_pair_err_i};
    wire [5:0] lvl_rise  = lvl & ~lvl_q;

    // ------------------------------------------------------------------
    // watchdog counters and reset event collection
    // ------------------------------------------------------------------
    wire       wd_fail   = wd_bad_i | wd_timeout_i;
    // plus two on failure, minus one on good refresh
    wire [3:0] wde_step  = wd_fail ? 4'(wde_cnt + fse_pkg::WDE_FAIL_STEP)
                         : (wd_ok_i && wde_cnt != fse_pkg::WDE_ZERO) ? 4'(wde_cnt - fse_pkg::WDE_OK_STEP) : wde_cnt;
    wire       wde_hit   = (wde_step >= fse_pkg::WDE_LIMIT);
    wire       ext_fall  = pin_upd[fse_pkg::PIN_EXT_RST_N] & ~pin_s3[fse_pkg::PIN_EXT_RST_N];
    wire       rst_event = ~deep & (ext_fall | (|lvl_rise) | spi_reset_req_i | wd_timeout_i
                         | (safety_init_phase_i & wd_bad_i) | wde_hit);
    wire [2:0] cnt_inc   = 3'(cnt + fse_pkg::CNT_ONE);
    // refresh past the limit earns a decrement
    wire       cnt_dec   = wd_ok_i & (refresh_cnt == fse_pkg::REFRESH_COUNT_LIMIT) & (cnt != fse_pkg::CNT_ZERO);
    wire       long_hit  = (long_cnt >= fse_pkg::LONG_W'(LONG_RST_CYC));
    wire       to_deep   = (rst_event & (cnt_inc >= final_lvl)) | long_hit;
    // only a wake transition or power-on leaves deep
    wire       wake_exit = deep & pin_upd[fse_pkg::PIN_WAKE];
    wire       restart   = wake_exit | (~deep & low_power_off_resume_i);
    // expected key is reversed and inverted challenge
    wire [7:0] key_exp   = ~{<<{wd_challenge_word_i}};
    wire       key_match = key_wr_i & (key_wdata_i == key_exp);
    wire       release_ok = ~fault_now & (cnt == fse_pkg::CNT_ZERO) & key_good & ~rst_event & ~deep;
    wire       reset_low  = deep | (pulse_cnt != '0) | ~pin_f[fse_pkg::PIN_EXT_RST_N] | ded | rst_short;
    wire       fs_low     = deep | fs_hold;

    // next values of the escalation state
    fse_pkg::fse_state_e next_state;
    logic [2:0]          next_cnt;
    logic                next_fs_hold;
    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_fs_hold = fs_hold;
        case (state)
            fse_pkg::ST_RUN: begin
                if (restart) begin
                    next_cnt     = fse_pkg::CNT_PRESET;
                    next_fs_hold = 1'b1;
                end else if (to_deep) begin
                    next_state   = fse_pkg::ST_DEEP;
                    next_cnt     = final_lvl;
                    next_fs_hold = 1'b1;
                end else if (rst_event) begin
                    next_cnt     = cnt_inc;
                    next_fs_hold = fs_hold | fault_now | (cnt_inc >= inter_lvl);
                end else begin
                    next_cnt     = cnt_dec ? 3'(cnt - fse_pkg::CNT_ONE) : cnt;
                    next_fs_hold = (fs_hold | fault_now) & ~release_ok;
                end
            end
            fse_pkg::ST_DEEP: begin
                if (wake_exit) begin
                    next_state   = fse_pkg::ST_RUN;
                    next_cnt     = fse_pkg::CNT_PRESET;
                    next_fs_hold = 1'b1;
                end
            end
            default: begin
                next_state   = fse_pkg::ST_DEEP;
                next_fs_hold = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers; power-on behaves as a start-up with counter at one
    // ------------------------------------------------------------------
    // start-up preset
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state   <= fse_pkg::ST_RUN;
            cnt     <= fse_pkg::CNT_PRESET;
            fs_hold <= 1'b1;
            lvl_q   <= '0;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            fs_hold <= next_fs_hold;
            lvl_q   <= lvl;
        end
    end

    // wrong refresh clears; limit then wrap
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            refresh_cnt <= fse_pkg::CNT_ZERO;
            wde_cnt     <= fse_pkg::WDE_ZERO;
        end else begin
            if (wd_fail) begin
                refresh_cnt <= fse_pkg::CNT_ZERO;
            end else if (wd_ok_i) begin
                refresh_cnt <= (refresh_cnt == fse_pkg::REFRESH_COUNT_LIMIT) ? fse_pkg::CNT_ZERO
                             : 3'(refresh_cnt + fse_pkg::REFRESH_STEP);
            end
            wde_cnt <= wde_hit ? fse_pkg::WDE_ZERO : wde_step;
        end
    end

    // reset pulse and low-time timers; power-on starts with one pulse
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pulse_cnt  <= fse_pkg::PULSE_W'(RST_PULSE_CYC);
            long_cnt   <= '0;
            fs_low_cnt <= '0;
        end else begin
            if (rst_event | wake_exit) begin
                pulse_cnt <= fse_pkg::PULSE_W'(RST_PULSE_CYC);
            end else if (pulse_cnt != '0) begin
                pulse_cnt <= pulse_cnt - 1'b1;
            end
            // count continuous low time outside deep
            long_cnt   <= (reset_low & ~deep & ~long_hit) ? fse_pkg::LONG_W'(long_cnt + 1'b1) : '0;
            fs_low_cnt <= ~fs_low ? 4'h0 : (fs_low_cnt == fse_pkg::SENSE_SETTLE) ? fs_low_cnt : 4'(fs_low_cnt + 1'b1);
        end
    end

    // wrong key clears, good key sets; flag set beats clear
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            key_good <= 1'b0;
            sec_flag <= 1'b0;
        end else begin
            if (key_wr_i) begin
                key_good <= key_match;
            end else if (release_ok | restart) begin
                key_good <= 1'b0;  // one key per release, never reused
            end
            sec_flag <= cfg_bus.sec | ded | (sec_flag & ~sec_flag_clr_i);
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mcu_reset_out_n_o <= 1'b0;
            failsafe_out_n_o  <= 1'b0;
            regulators_off_o  <= 1'b0;
        end else begin
            mcu_reset_out_n_o <= ~reset_low;
            failsafe_out_n_o  <= ~fs_low;
            regulators_off_o  <= deep;
        end
    end

    assign deep_failsafe_o       = deep;
    assign reset_count_o         = cnt;
    assign cfg_rdata_o           = cfg;
    assign sec_flag_o            = sec_flag;
    assign double_error_detect_o = ded;
    assign key_good_o            = key_good;

endmodule

// file: testbench/fse_mcu_model.sv
// mcu partner: works out the release key and gates threshold writes
// assumes the challenge word is stable while a key write is offered
`timescale 1ns/1ps
module fse_mcu_model (
    input  wire logic       safety_init_phase_i,
    input  wire logic       cfg_req_i,
    input  wire logic [7:0] wd_challenge_word_i,
    output logic            cfg_wr_o,
    output logic [7:0]      key_o
);
    always_comb for (int i = 0; i < 8; i++) key_o[i] = ~wd_challenge_word_i[7 - i];
    assign cfg_wr_o = cfg_req_i && safety_init_phase_i;
endmodule

// file: testbench/fse_escalation_sva.sv
// checker: escalation outputs against counter, key and deep rules
// assumes it is bound onto the escalation top, single clock domain
`timescale 1ns/1ps
module fse_escalation_sva #(parameter int LONG_RST_CYC = fse_pkg::LONG_RST_CYC) (
    input wire logic                      mclk_i,
    input wire logic                      rst_i,
    input wire logic                      spi_reset_req_i,
    input wire logic                      low_power_off_resume_i,
    input wire logic                      key_wr_i,
    input wire logic [7:0]                key_wdata_i,
    input wire logic [7:0]                wd_challenge_word_i,
    input wire logic                      mcu_reset_out_n_o,
    input wire logic                      failsafe_out_n_o,
    input wire logic                      regulators_off_o,
    input wire logic                      deep_failsafe_o,
    input wire logic [2:0]                reset_count_o,
    input wire logic [fse_pkg::CFG_W-1:0] cfg_rdata_o,
    input wire logic                      double_error_detect_o,
    input wire logic                      key_good_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] exp_key;
    int         low_cnt;
    // key recomputed so a mirrored bit order shows
    always_comb for (int i = 0; i < 8; i++) exp_key[i] = ~wd_challenge_word_i[7 - i];
    // reset low time outside deep
    always_ff @(posedge mclk_i or posedge rst_i) low_cnt <= rst_i ? 0 : (!mcu_reset_out_n_o && !deep_failsafe_o) ? low_cnt + 1 : 0;
    a_deep_outputs: assert property (deep_failsafe_o && $past(deep_failsafe_o) |->
        regulators_off_o && !mcu_reset_out_n_o && !failsafe_out_n_o) else $error("deep outputs released");
    a_event_adds_one: assert property (spi_reset_req_i && !deep_failsafe_o && !low_power_off_resume_i &&
        reset_count_o < (cfg_rdata_o[0] ? 3'h1 : 3'h5) |=> reset_count_o == $past(reset_count_o) + 3'h1) else $error("count step");
    a_inter_level_fs: assert property (reset_count_o >= (cfg_rdata_o[0] ? 3'h1 : 3'h3) |-> ##2 !failsafe_out_n_o)
        else $error("failsafe missing");
    a_deep_final: assert property ($rose(deep_failsafe_o) |-> reset_count_o == (cfg_rdata_o[0] ? 3'h2 : 3'h6))
        else $error("deep count level");
    a_deep_frozen: assert property (deep_failsafe_o && $past(deep_failsafe_o) |-> $stable(reset_count_o))
        else $error("count moved in deep");
    a_key_compare: assert property (key_wr_i && !low_power_off_resume_i |=> key_good_o == $past(key_wdata_i == exp_key))
        else $error("key compare");
    a_release_gate: assert property ($rose(failsafe_out_n_o) |-> reset_count_o == 3'h0 && !double_error_detect_o)
        else $error("early release");
    a_double_both: assert property (double_error_detect_o |-> ##2 !mcu_reset_out_n_o && !failsafe_out_n_o)
        else $error("double error outputs");
    a_long_reset: assert property (low_cnt <= LONG_RST_CYC + 3) else $error("long reset not escalated");
    c_deep: cover property ($rose(deep_failsafe_o));
    c_release: cover property ($rose(failsafe_out_n_o));
    c_double: cover property ($rose(double_error_detect_o));
endmodule
bind fse_escalation fse_escalation_sva #(.LONG_RST_CYC(LONG_RST_CYC)) sva_u (.*);

// file: testbench/test_fse_escalation.sv
// bench: drives the escalation block, checks it against a counter model
// assumes the mcu model and bound checker compile first
`timescale 1ns/1ps
module test_fse_escalation;
    logic        mclk_i = 0, rst_i = 1, wake_pin_i = 0, ext_reset_n_i = 1, safety_init_phase_i = 1, cfg_wr_i;
    logic [10:0] ev = 11'h000;
    logic [7:0]  cfg_wdata_i = 8'h00, key_wdata_i = 8'h00, wd_challenge_word_i = 8'h00, mkey, cfg_rdata_o;
    logic [12:0] cfg_upset_i = 13'h0000;
    logic        mcu_reset_out_n_o, failsafe_out_n_o, regulators_off_o, deep_failsafe_o, sec_flag_o, key_good_o;
    logic        double_error_detect_o;
    logic [2:0]  reset_count_o;
    int          num_errors = 0, n_checks = 0, exp_cnt = 1, ref_n = 0, fin = 6, seed;

    // pin readbacks follow the driven outputs, so no short is seen
    fse_escalation #(.RST_PULSE_CYC(8), .LONG_RST_CYC(200)) dut_u (.mclk_i, .rst_i, .wake_pin_i, .ext_reset_n_i,
        .rst_sense_i(mcu_reset_out_n_o), .fs_sense_i(failsafe_out_n_o), .safety_init_phase_i, .cfg_wr_i, .cfg_wdata_i,
        .low_power_off_resume_i(ev[4]), .cfg_upset_i, .key_wr_i(ev[2]), .key_wdata_i, .wd_challenge_word_i,
        .wd_ok_i(ev[0]), .wd_bad_i(ev[1]), .wd_timeout_i(ev[6]), .io_pair_err_i(ev[9]), .undervolt_i(ev[7]),
        .overvolt_i(ev[8]), .core_fb_err_i(ev[10]), .analog_self_test_fail_i(1'b0), .spi_reset_req_i(ev[5]),
        .sec_flag_clr_i(1'b0), .mcu_reset_out_n_o, .failsafe_out_n_o, .regulators_off_o, .deep_failsafe_o,
        .reset_count_o, .cfg_rdata_o, .sec_flag_o, .double_error_detect_o, .key_good_o);
    fse_mcu_model mcu_u (.safety_init_phase_i, .cfg_req_i(ev[3]), .wd_challenge_word_i, .cfg_wr_o(cfg_wr_i), .key_o(mkey));

    initial forever #50 mclk_i = ~mclk_i;
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", s, e, g);
            num_errors++;
        end
    endtask
    task automatic stop_test();
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // power-on reset held three cycles, then the start-up reset pulse
    task automatic por();
        rst_i <= 1'b1;
        tick(3);
        rst_i <= 1'b0;
        tick(12);
        exp_cnt = 1;
        fin = 6;
    endtask
    // one-cycle request, then the counter model
    task automatic pulse(input int k);
        ev <= 11'h001 << k;
        tick(1);
        ev <= 11'h000;
        tick(2);
        #1;
        if (k == 4) exp_cnt = 1;
        else if (k >= 5 && exp_cnt < fin) exp_cnt++;
        else if (k == 0 && exp_cnt > 0 && ref_n == 6) begin
            exp_cnt--;
            ref_n = 0;
        end else if (k == 0) ref_n++;
        if (k == 1 || k == 6) ref_n = 0;
        chk("count", 8'(exp_cnt), 8'(reset_count_o));
        @(posedge mclk_i);
    endtask

    initial begin
        seed = $urandom(52380);
        wd_challenge_word_i <= 8'($urandom);
        por();
        chk("count", 8'h01, 8'(reset_count_o));
        chk("failsafe", 8'h00, 8'(failsafe_out_n_o));
        pulse(3);
        safety_init_phase_i <= 1'b0;
        for (int i = 0; i < 11; i++) pulse(i == 3 ? 1 : 0);
        key_wdata_i <= mkey ^ (8'h01 << $urandom_range(7));
        pulse(2);
        tick(3);
        chk("failsafe", 8'h00, 8'(failsafe_out_n_o));
        key_wdata_i <= mkey;
        pulse(2);
        tick(3);
        chk("failsafe", 8'h01, 8'(failsafe_out_n_o));
        pulse(4);
        tick(2);
        chk("failsafe", 8'h00, 8'(failsafe_out_n_o));
        for (int i = 5; i < 11; i++) pulse(i);
        chk("deep", 8'h0F, 8'({deep_failsafe_o, regulators_off_o, !mcu_reset_out_n_o, !failsafe_out_n_o}));
        wake_pin_i <= 1'b1;
        tick(8);
        exp_cnt = 1;
        chk("wake exit", 8'h01, 8'({deep_failsafe_o, reset_count_o}));
        safety_init_phase_i <= 1'b1;
        cfg_wdata_i <= 8'h01;
        pulse(3);
        safety_init_phase_i <= 1'b0;
        fin = 2;
        pulse(5);
        chk("deep", 8'h01, 8'(deep_failsafe_o));
        por();
        ext_reset_n_i <= 1'b0;
        tick(220);
        chk("deep", 8'h01, 8'(deep_failsafe_o));
        ext_reset_n_i <= 1'b1;
        por();
        cfg_upset_i <= 13'h0004;
        tick(1);
        cfg_upset_i <= 13'h0000;
        tick(2);
        chk("single upset", 8'h80, {sec_flag_o, cfg_rdata_o[6:0]});
        por();
        cfg_upset_i <= 13'h0006;
        tick(1);
        cfg_upset_i <= 13'h0000;
        tick(3);
        chk("double upset", 8'h07, 8'({double_error_detect_o, !mcu_reset_out_n_o, !failsafe_out_n_o}));
        stop_test();
    end
    // hang guard, about five times the run
    initial begin
        tick(2000);
        num_errors++;
        stop_test();
    end
endmodule
